/* File: test/gauge_convergence_config_regs_bench.sv */
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Self-checking bench for the gauge register bank
// ----------------------------------------------------------------
module gauge_convergence_config_regs_bench;
    logic                    clock;
    logic                    rst_n;
    gcc_pkg::gcc_ahb_req_t   req;
    gcc_pkg::gcc_ahb_req_t   req_bus;
    gcc_pkg::gcc_ahb_rsp_t   rsp;
    gcc_pkg::gcc_gauge_in_t  gin;
    gcc_pkg::gcc_gauge_out_t gout;
    logic                    irq;
    int                      fails;
    int                      n_compared;
    int                      cycles;
    logic [31:0]             rd_val;

    // Single slave: its hreadyout is the bus hready
    always_comb begin
        req_bus        = req;
        req_bus.hready = rsp.hreadyout;
    end

    gcc_regs DUT (
        .clock     (clock),
        .rst_n     (rst_n),
        .ahb_req   (req_bus),
        .ahb_rsp   (rsp),
        .gauge_in  (gin),
        .gauge_out (gout),
        .irq       (irq)
    );

    // Clock generation
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    // Verdict and end of run
    task automatic conclude();
        if (fails == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Compare one value
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One single AHB-Lite transfer, address phase then data phase
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        @(posedge clock);
        req.hsel   <= 1'b1;
        req.htrans <= 2'h2;
        req.haddr  <= {22'h0, idx, 2'h0};
        req.hwrite <= wr;
        req.hsize  <= 3'h2;
        do @(posedge clock); while (rsp.hreadyout !== 1'b1);
        req.hsel   <= 1'b0;
        req.htrans <= 2'h0;
        req.hwdata <= wd;
        do @(posedge clock); while (rsp.hreadyout !== 1'b1);
        rd_val = rsp.hrdata;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
        bus(1'b1, idx, wd);
    endtask

    task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
        bus(1'b0, idx, 32'h0000_0000);
        check(rd_val, exp);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask

    // Timeout watchdog
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            conclude();
        end
    end

    // Main sequence
    initial begin
        rst_n = 1'b0;
        req = '0;
        req.hready = 1'b1;
        gin = '0;
        fails = 0;
        n_compared = 0;
        cycles = 0;
        tick(10);
        rst_n <= 1'b1;
        tick(3);
        rd(gcc_pkg::IDX_TEMP_GAIN, 32'h0000_4000);
        rd(gcc_pkg::IDX_CONVG_CFG, 32'h0000_0000);
        wr(gcc_pkg::IDX_CONVG_CFG, 32'hFFFF_FFFF);
        rd(gcc_pkg::IDX_CONVG_CFG, 32'h0000_FFFF);
        tick(3);
        check({24'h0, gout.low_capacity_threshold}, 32'h0000_004F);
        check({28'h0, gout.slope_shallow_factor}, 32'h0000_000F);
        gin.learn_step_index <= 3'h7;
        tick(3);
        check({24'h0, gout.low_capacity_threshold}, 32'h0000_001E);
        wr(gcc_pkg::IDX_CONVG_CFG, 32'h0000_1288);
        gin.averaged_cell_voltage <= 16'h0D00;
        gin.low_voltage_threshold <= 16'h0E00;
        gin.cell_voltage          <= 16'h0DAC;
        gin.empty_voltage         <= 16'h0CE4;
        tick(3);
        check({31'h0, gout.volt_bend_active}, 32'h0000_0001);
        check({31'h0, gout.cap_bend_active}, 32'h0000_0000);
        check({16'h0, gout.volt_bend_den}, 32'h0000_0064);
        check({16'h0, gout.volt_bend_num}, 32'h0000_00C8);
        check({28'h0, gout.slope_shallow_factor}, 32'h0000_0001);
        gin.averaged_cell_voltage <= 16'h0F00;
        wr(gcc_pkg::IDX_CHARGE_TIME_FILTER_CONFIG, 32'h0000_FFFF);
        rd(gcc_pkg::IDX_CHARGE_TIME_FILTER_CONFIG, 32'h0000_0007);
        check({31'h0, gout.cap_bend_active}, 32'h0000_0001);
        wr(gcc_pkg::IDX_CHARGE_TIME_FILTER_CONFIG, 32'h0000_0000);
        wr(gcc_pkg::IDX_FULL_HIB_STAT, 32'h0000_FFFF);
        rd(gcc_pkg::IDX_FULL_HIB_STAT, 32'h0000_0000);
        rd(8'hFF, 32'h0000_0000);
        // Full detect with hysteresis, hibernate mirror, interrupt path
        wr(gcc_pkg::IDX_IRQ_MASK, 32'h0000_0001);
        gin.voltage_based_charge_pct <= 16'h6301;
        gin.hibernate_config_bit     <= 1'b1;
        tick(3);
        check({31'h0, irq}, 32'h0000_0001);
        rd(gcc_pkg::IDX_FULL_HIB_STAT, 32'h0000_0022);
        gin.voltage_based_charge_pct <= 16'h6290;
        tick(3);
        rd(gcc_pkg::IDX_FULL_HIB_STAT, 32'h0000_0022);
        rd(gcc_pkg::IDX_IRQ_STATUS, 32'h0000_0001);
        check({31'h0, irq}, 32'h0000_0000);
        gin.voltage_based_charge_pct <= 16'h627F;
        tick(3);
        check({31'h0, irq}, 32'h0000_0000);
        rd(gcc_pkg::IDX_FULL_HIB_STAT, 32'h0000_0002);
        rd(gcc_pkg::IDX_IRQ_STATUS, 32'h0000_0002);
        // Constant-voltage capture and half-life
        gin.mixed_capacity   <= 16'h1234;
        gin.cc_current       <= 16'h0100;
        gin.averaged_current <= 16'h0100;
        gin.cv_start <= 1'b1;
        tick(1);
        gin.cv_start <= 1'b0;
        repeat (5) begin
            tick(1);
            gin.time_tick <= 1'b1;
            tick(1);
            gin.time_tick <= 1'b0;
        end
        tick(2);
        gin.averaged_current <= 16'h007F;
        tick(3);
        rd(gcc_pkg::IDX_CV_START_CAP, 32'h0000_1234);
        rd(gcc_pkg::IDX_CV_HALF_LIFE, 32'h0000_0005);
        // Metal tempco default and restore
        gin.stored_metal_tempco <= 16'hABCD;
        for (int k = 0; k < 2; k++) begin
            wr(gcc_pkg::IDX_CONTROL, (k == 0) ? 32'h0000_0002 : 32'h0000_0004);
            gin.tempco_restore <= 1'b1;
            tick(1);
            gin.tempco_restore <= 1'b0;
            rd(gcc_pkg::IDX_METAL_TEMPCO, (k == 0) ? 32'h0000_20C8 : 32'h0000_ABCD);
        end
        check({16'h0, gout.metal_tempco}, 32'h0000_ABCD);
        // Temperature: base, ground compensation, curvature both sides
        gin.averaged_current <= 16'h0000;
        gin.thermistor_input_reading <= 16'h1000;
        wr(gcc_pkg::IDX_CONTROL, 32'h0000_0000);
        wr(gcc_pkg::IDX_TEMP_OFFSET, 32'h0000_0010);
        tick(3);
        check({16'h0, gout.temperature}, 32'h0000_1020);
        wr(gcc_pkg::IDX_CURVATURE, 32'h0000_0100);
        gin.averaged_current <= 16'h0400;
        tick(3);
        check({16'h0, gout.temperature}, 32'h0000_101F);
        gin.averaged_current <= 16'h0000;
        wr(gcc_pkg::IDX_TEMP_OFFSET, 32'h0000_0000);
        wr(gcc_pkg::IDX_CURVATURE, 32'h0000_0001);
        wr(gcc_pkg::IDX_CONTROL, 32'h0000_0001);
        gin.thermistor_input_reading <= 16'h3400;
        tick(3);
        check({16'h0, gout.temperature}, 32'h0000_3500);
        gin.thermistor_input_reading <= 16'h0400;
        tick(3);
        check({16'h0, gout.temperature}, 32'h0000_03C0);
        rd(gcc_pkg::IDX_TEMP_RESULT, 32'h0000_03C0);
        conclude();
    end
endmodule

/* File: test/gcc_regs_asserts.sv */
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Port checker for the gauge register bank
// ----------------------------------------------------------------
module gcc_regs_asserts (
    input wire logic                   clock,
    input wire logic                   rst_n,
    input wire gcc_pkg::gcc_ahb_req_t  ahb_req,
    input wire gcc_pkg::gcc_ahb_rsp_t  ahb_rsp,
    input wire gcc_pkg::gcc_gauge_in_t gauge_in,
    input wire gcc_pkg::gcc_gauge_out_t gauge_out,
    input wire logic                   irq
);
    logic [1:0] up_q;
    logic       live;
    logic       rd_taken;

    // Cycles since reset release, saturating
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            up_q <= 2'h0;
        end else if (up_q != 2'h3) begin
            up_q <= up_q + 2'h1;
        end
    end

    // Read address phase accepted on this edge
    assign live     = (up_q == 2'h3);
    assign rd_taken = ahb_req.hsel && ahb_req.htrans[1] && ahb_req.hready && !ahb_req.hwrite;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    a_ready_high: assert property (ahb_rsp.hreadyout == 1'b1)
        else $error("hreadyout dropped");
    a_resp_okay: assert property (ahb_rsp.hresp == 1'b0)
        else $error("hresp not OKAY");
    a_upper_zero: assert property (ahb_rsp.hrdata[31:16] == 16'h0000)
        else $error("upper read half not zero");
    a_unmapped_zero: assert property (rd_taken && ahb_req.haddr[9:2] >= 8'hD0
        |=> ahb_rsp.hrdata == 32'h0000_0000) else $error("unmapped read not zero");
    a_rdata_holds: assert property (live && !rd_taken |=> $stable(ahb_rsp.hrdata))
        else $error("read data changed without a read");
    a_bend_exclusive: assert property (!(gauge_out.cap_bend_active && gauge_out.volt_bend_active))
        else $error("both bend modes active");
    a_volt_bend_cond: assert property (live &&
        gauge_in.averaged_cell_voltage < gauge_in.low_voltage_threshold
        |=> gauge_out.volt_bend_active) else $error("voltage bend not active");
    a_threshold_max: assert property (gauge_out.low_capacity_threshold <= 8'h4F)
        else $error("threshold above range");
    a_quiet_start: assert property (up_q < 2'h2 |-> !irq && gauge_out == '0)
        else $error("outputs active right after reset");

    c_irq: cover property (irq);
    c_volt_bend: cover property (gauge_out.volt_bend_active);
    c_cv_start: cover property (gauge_in.cv_start);
endmodule

bind gcc_regs gcc_regs_asserts u_chk (
    .clock     (clock),
    .rst_n     (rst_n),
    .ahb_req   (ahb_req),
    .ahb_rsp   (ahb_rsp),
    .gauge_in  (gauge_in),
    .gauge_out (gauge_out),
    .irq       (irq)
);

/* File: verilog/gcc_pkg.sv */
package gcc_pkg;

    // ----------------------------------------------------------------
    // Register indices (byte address = index * 4)
    // ----------------------------------------------------------------
    localparam logic [7:0] IDX_TEMP_GAIN      = 8'h2C;
    localparam logic [7:0] IDX_TEMP_OFFSET    = 8'h2D;
    localparam logic [7:0] IDX_CONVG_CFG      = 8'h49;
    localparam logic [7:0] IDX_FULL_HIB_STAT  = 8'hB0;
    localparam logic [7:0] IDX_CHARGE_TIME_FILTER_CONFIG        = 8'hB5;
    localparam logic [7:0] IDX_CV_START_CAP   = 8'hB6;
    localparam logic [7:0] IDX_CV_HALF_LIFE   = 8'hB7;
    localparam logic [7:0] IDX_METAL_TEMPCO   = 8'hB8;
    localparam logic [7:0] IDX_CURVATURE      = 8'hB9;
    localparam logic [7:0] IDX_IRQ_STATUS     = 8'hC0;
    localparam logic [7:0] IDX_IRQ_MASK       = 8'hC1;
    localparam logic [7:0] IDX_CONTROL        = 8'hC2;
    localparam logic [7:0] IDX_TEMP_RESULT    = 8'hC3;
    localparam logic [7:0] IDX_LOW_THRESHOLD  = 8'hC4;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int CV_LOW_THR_LSB    = 12;
    localparam int CV_LV_OFF_LSB     = 7;
    localparam int CV_SLOPE_LSB      = 3;
    localparam int CV_PER_STEP_LSB   = 0;
    localparam int ST_FULL_BIT       = 5;
    localparam int ST_HIB_BIT        = 1;
    localparam int CTL_CURVE_EN_BIT  = 0;
    localparam int CTL_METAL_EN_BIT  = 1;
    localparam int CTL_OTP_EN_BIT    = 2;
    localparam int IRQ_FULL_SET      = 0;
    localparam int IRQ_FULL_CLR      = 1;
    localparam int IRQ_CV_START      = 2;
    localparam int IRQ_HALF_DONE     = 3;
    localparam int IRQ_BITS          = 4;

    // ----------------------------------------------------------------
    // Reset values and constants
    // ----------------------------------------------------------------
    localparam logic [15:0] RST_TEMP_GAIN     = 16'h4000;
    localparam logic [15:0] RST_ZERO          = 16'h0000;
    localparam logic [15:0] METAL_TEMPCO_DEF  = 16'h20C8;
    localparam logic [15:0] FULL_SET_LEVEL    = 16'h6300;  // 99.0% in 1/256 %
    localparam logic [15:0] FULL_CLR_LEVEL    = 16'h6280;  // 98.5% in 1/256 %
    localparam logic [16:0] CURVE_CENTER      = 17'h01400;
    localparam int          CURVE_DIV_SHIFT   = 18;        // divide by 0x40000
    localparam int          GAIN_DIV_SHIFT    = 14;        // divide by 0x4000
    localparam int          GND_COMP_SHIFT    = 10;
    localparam logic [7:0]  LOW_THR_STEP_PCT  = 8'h02;
    localparam logic [15:0] LV_OFF_STEP_MV    = 16'h0014;
    localparam logic [2:0]  LAST_LEARN_STEP   = 3'h7;
    localparam logic [15:0] HALF_CNT_MAX      = 16'hFFFF;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [0:0] {
        GCC_CV_IDLE   = 1'b0,
        GCC_CV_TIMING = 1'b1
    } gcc_cv_state_t;

    typedef struct packed {
        logic        hsel;
        logic [31:0] haddr;
        logic [1:0]  htrans;
        logic        hwrite;
        logic [2:0]  hsize;
        logic [31:0] hwdata;
        logic        hready;
    } gcc_ahb_req_t;

    typedef struct packed {
        logic        hreadyout;
        logic        hresp;
        logic [31:0] hrdata;
    } gcc_ahb_rsp_t;

    typedef struct packed {
        logic [15:0] thermistor_input_reading;
        logic [15:0] averaged_current;
        logic [15:0] averaged_cell_voltage;
        logic [15:0] cell_voltage;
        logic [15:0] empty_voltage;
        logic [15:0] low_voltage_threshold;
        logic [15:0] voltage_based_charge_pct;
        logic [15:0] reported_charge_pct;
        logic [2:0]  learn_step_index;
        logic        hibernate_config_bit;
        logic [15:0] mixed_capacity;
        logic        cv_start;
        logic [15:0] cc_current;
        logic        time_tick;
        logic [15:0] stored_metal_tempco;
        logic        tempco_restore;
    } gcc_gauge_in_t;

    typedef struct packed {
        logic [15:0] temperature;
        logic [7:0]  low_capacity_threshold;
        logic [3:0]  slope_shallow_factor;
        logic        cap_bend_active;
        logic        volt_bend_active;
        logic [15:0] volt_bend_num;
        logic [15:0] volt_bend_den;
        logic [15:0] metal_tempco;
    } gcc_gauge_out_t;

endpackage

/* File: verilog/gcc_regs.sv */
`timescale 1ns/1ps

// Overview of operation
// - Convergence bits 15:12 give a low capacity threshold in 2% steps, 0 to 30%.
// - Below the low voltage threshold, capacity bends by (cell - empty) over the offset.
// - Bits 11:7 give the low voltage offset in 20mV steps, and voltage bending replaces it.
// - Bits 6:3 give the slope shallowing factor in sixteenths below the threshold.
// - Bits 2:0 raise the threshold by field x 1% x (7 - learn step).
// - Full flag sets above 99% voltage charge and clears only below 98.5%.
// - Status bit 1 mirrors the hibernate configuration bit.
// - Time-to-full config bits 2:0 pick the filter rate for the half life.
// - Mixed capacity is captured when constant-voltage charging begins.
// - Half life is the time from constant-voltage start until current drops below half.
// - Metal tempco is restored from its stored copy when restore is enabled.
// - With metal calc on and restore off, the tempco loads 0x20C8.
// - Curvature bits 15:8 compensate ground resistance with battery current.
// - With curvature on, add bits 7:0 x (T-0x1400)^2 / 0x40000, negated below 0x1400.
// - Base temperature is reading x gain / 0x4000 plus twice the offset.
module gcc_regs (
    input  wire logic                    clock,
    input  wire logic                    rst_n,
    input  wire gcc_pkg::gcc_ahb_req_t   ahb_req,
    output gcc_pkg::gcc_ahb_rsp_t        ahb_rsp,
    input  wire gcc_pkg::gcc_gauge_in_t  gauge_in,
    output gcc_pkg::gcc_gauge_out_t      gauge_out,
    output logic                         irq
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        gcc_pkg::gcc_ahb_rsp_t   rsp;
        logic                    dp_write;
        logic [7:0]              dp_index;
        logic [15:0]             temp_gain;
        logic [15:0]             temp_offset;
        logic [15:0]             convg_cfg;
        logic                    full_detect_flag;
        logic [2:0]              charge_time_filter_config;
        logic [15:0]             cv_start_cap;
        logic [15:0]             cv_half_life;
        logic [15:0]             metal_tempco;
        logic [15:0]             curvature;
        logic [2:0]              control;
        logic [3:0]              irq_status;
        logic [3:0]              irq_mask;
        gcc_pkg::gcc_cv_state_t  cv_state;
        logic [15:0]             half_cnt;
        gcc_pkg::gcc_gauge_out_t gout;
        logic                    irq;
    } gcc_state_t;

    gcc_state_t    st_q;
    gcc_state_t    st_d;
    logic [1:0]    rst_sync_q;
    logic          rst_int_n;

    // ----------------------------------------------------------------
    // Reset release
    // ----------------------------------------------------------------
    // Two stages so release is clean against the clock
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_int_n = rst_sync_q[1];

    // ----------------------------------------------------------------
    // Combinational datapath
    // ----------------------------------------------------------------
    logic signed [31:0] gnd_prod;
    logic signed [15:0] ain_comp;
    logic signed [31:0] gain_prod;
    logic signed [17:0] base_temp;
    logic signed [17:0] curve_diff;
    logic        [35:0] curve_sq;
    logic        [47:0] curve_prod;
    logic        [17:0] curve_term;
    logic signed [17:0] final_temp;
    logic        [7:0]  eff_thr;
    logic        [15:0] lv_off_mv;
    logic               addr_phase;
    logic [15:0]        half_meas;
    logic signed [16:0] half_delta;
    logic [15:0]        rd_val;
    logic [3:0]         irq_set;

    // Temperature chain: ground comp, gain/offset, curvature
    always_comb begin
        gnd_prod   = $signed({8'h00, st_q.curvature[15:8]})
                   * $signed(gauge_in.averaged_current);
        ain_comp   = 16'($signed(gauge_in.thermistor_input_reading)
                   - 16'(gnd_prod >>> gcc_pkg::GND_COMP_SHIFT));
        gain_prod  = ain_comp * $signed(st_q.temp_gain);
        base_temp  = 18'(gain_prod >>> gcc_pkg::GAIN_DIV_SHIFT)
                   + 18'({{2{st_q.temp_offset[15]}}, st_q.temp_offset} <<< 1);
        curve_diff = base_temp - $signed({1'b0, gcc_pkg::CURVE_CENTER});
        curve_sq   = 36'(curve_diff * curve_diff);
        curve_prod = 48'(curve_sq) * 48'(st_q.curvature[7:0]);
        curve_term = 18'(curve_prod >> gcc_pkg::CURVE_DIV_SHIFT);
        if (!st_q.control[gcc_pkg::CTL_CURVE_EN_BIT]) begin
            final_temp = base_temp;
        end else if (curve_diff < 0) begin
            final_temp = base_temp - $signed(curve_term);
        end else begin
            final_temp = base_temp + $signed(curve_term);
        end
    end

    // Threshold and offset scaling
    always_comb begin
        eff_thr   = 8'(st_q.convg_cfg[15:12]) * gcc_pkg::LOW_THR_STEP_PCT
                  + 8'(st_q.convg_cfg[2:0])
                  * 8'(gcc_pkg::LAST_LEARN_STEP - gauge_in.learn_step_index);
        lv_off_mv = 16'(st_q.convg_cfg[11:7]) * gcc_pkg::LV_OFF_STEP_MV;
    end

    // Half-life filter step
    always_comb begin
        half_meas  = st_q.half_cnt;
        half_delta = $signed({1'b0, half_meas}) - $signed({1'b0, st_q.cv_half_life});
    end

    // Read mux for the address phase
    always_comb begin
        rd_val = 16'h0000;
        case (ahb_req.haddr[9:2])
            gcc_pkg::IDX_TEMP_GAIN:     rd_val = st_q.temp_gain;
            gcc_pkg::IDX_TEMP_OFFSET:   rd_val = st_q.temp_offset;
            gcc_pkg::IDX_CONVG_CFG:     rd_val = st_q.convg_cfg;
            gcc_pkg::IDX_FULL_HIB_STAT: begin
                rd_val[gcc_pkg::ST_FULL_BIT] = st_q.full_detect_flag;
                rd_val[gcc_pkg::ST_HIB_BIT]  = gauge_in.hibernate_config_bit;
            end
            gcc_pkg::IDX_CHARGE_TIME_FILTER_CONFIG:       rd_val = {13'h0000, st_q.charge_time_filter_config};
            gcc_pkg::IDX_CV_START_CAP:  rd_val = st_q.cv_start_cap;
            gcc_pkg::IDX_CV_HALF_LIFE:  rd_val = st_q.cv_half_life;
            gcc_pkg::IDX_METAL_TEMPCO:  rd_val = st_q.metal_tempco;
            gcc_pkg::IDX_CURVATURE:     rd_val = st_q.curvature;
            gcc_pkg::IDX_IRQ_STATUS:    rd_val = {12'h000, st_q.irq_status};
            gcc_pkg::IDX_IRQ_MASK:      rd_val = {12'h000, st_q.irq_mask};
            gcc_pkg::IDX_CONTROL:       rd_val = {13'h0000, st_q.control};
            gcc_pkg::IDX_TEMP_RESULT:   rd_val = st_q.gout.temperature;
            gcc_pkg::IDX_LOW_THRESHOLD: rd_val = {8'h00, st_q.gout.low_capacity_threshold};
            default:                    rd_val = 16'h0000;
        endcase
    end

    assign addr_phase = ahb_req.hsel & ahb_req.htrans[1] & ahb_req.hready;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        st_d    = st_q;
        irq_set = 4'h0;

        // Bus: zero wait state, always OKAY
        st_d.rsp.hreadyout = 1'b1;
        st_d.rsp.hresp     = 1'b0;
        st_d.dp_write      = addr_phase & ahb_req.hwrite;
        if (addr_phase) begin
            st_d.dp_index = ahb_req.haddr[9:2];
        end
        if (addr_phase && !ahb_req.hwrite) begin
            st_d.rsp.hrdata = {16'h0000, rd_val};
        end

        // Register writes in the data phase
        if (st_q.dp_write) begin
            case (st_q.dp_index)
                gcc_pkg::IDX_TEMP_GAIN:    st_d.temp_gain    = ahb_req.hwdata[15:0];
                gcc_pkg::IDX_TEMP_OFFSET:  st_d.temp_offset  = ahb_req.hwdata[15:0];
                gcc_pkg::IDX_CONVG_CFG:    st_d.convg_cfg    = ahb_req.hwdata[15:0];
                gcc_pkg::IDX_CHARGE_TIME_FILTER_CONFIG:      st_d.charge_time_filter_config      = ahb_req.hwdata[2:0];
                gcc_pkg::IDX_CV_START_CAP: st_d.cv_start_cap = ahb_req.hwdata[15:0];
                gcc_pkg::IDX_CV_HALF_LIFE: st_d.cv_half_life = ahb_req.hwdata[15:0];
                gcc_pkg::IDX_METAL_TEMPCO: st_d.metal_tempco = ahb_req.hwdata[15:0];
                gcc_pkg::IDX_CURVATURE:    st_d.curvature    = ahb_req.hwdata[15:0];
                gcc_pkg::IDX_IRQ_MASK:     st_d.irq_mask     = ahb_req.hwdata[3:0];
                gcc_pkg::IDX_CONTROL:      st_d.control      = ahb_req.hwdata[2:0];
                default:                   st_d.control      = st_q.control;
            endcase
        end

        // Full detect with hysteresis
        if (!st_q.full_detect_flag
            && gauge_in.voltage_based_charge_pct > gcc_pkg::FULL_SET_LEVEL) begin
            st_d.full_detect_flag = 1'b1;
            irq_set[gcc_pkg::IRQ_FULL_SET] = 1'b1;
        end else if (st_q.full_detect_flag
            && gauge_in.voltage_based_charge_pct < gcc_pkg::FULL_CLR_LEVEL) begin
            st_d.full_detect_flag = 1'b0;
            irq_set[gcc_pkg::IRQ_FULL_CLR] = 1'b1;
        end

        // Constant-voltage phase tracking
        case (st_q.cv_state)
            gcc_pkg::GCC_CV_IDLE: begin
                if (gauge_in.cv_start) begin
                    st_d.cv_start_cap = gauge_in.mixed_capacity;
                    st_d.half_cnt     = 16'h0000;
                    st_d.cv_state     = gcc_pkg::GCC_CV_TIMING;
                    irq_set[gcc_pkg::IRQ_CV_START] = 1'b1;
                end
            end
            gcc_pkg::GCC_CV_TIMING: begin
                if (gauge_in.averaged_current < (gauge_in.cc_current >> 1)) begin
                    // Filtered update: new = old + (meas - old) >> rate
                    st_d.cv_half_life = 16'($signed({1'b0, st_q.cv_half_life})
                                      + (half_delta >>> st_q.charge_time_filter_config));
                    st_d.cv_state     = gcc_pkg::GCC_CV_IDLE;
                    irq_set[gcc_pkg::IRQ_HALF_DONE] = 1'b1;
                end else if (gauge_in.time_tick
                             && st_q.half_cnt != gcc_pkg::HALF_CNT_MAX) begin
                    st_d.half_cnt = st_q.half_cnt + 16'h0001;
                end
            end
            default: begin
                st_d.cv_state = gcc_pkg::GCC_CV_IDLE;
            end
        endcase

        // Tempco restore or copper default
        if (gauge_in.tempco_restore) begin
            if (st_q.control[gcc_pkg::CTL_OTP_EN_BIT]) begin
                st_d.metal_tempco = gauge_in.stored_metal_tempco;
            end else if (st_q.control[gcc_pkg::CTL_METAL_EN_BIT]) begin
                st_d.metal_tempco = gcc_pkg::METAL_TEMPCO_DEF;
            end
        end

        // Sticky status: read clears, a new event wins
        if (addr_phase && !ahb_req.hwrite
            && ahb_req.haddr[9:2] == gcc_pkg::IDX_IRQ_STATUS) begin
            st_d.irq_status = irq_set;
        end else begin
            st_d.irq_status = st_q.irq_status | irq_set;
        end
        st_d.irq = |(st_d.irq_status & st_d.irq_mask);

        // Gauge-facing outputs
        st_d.gout.temperature            = 16'(final_temp);
        st_d.gout.low_capacity_threshold = eff_thr;
        st_d.gout.slope_shallow_factor   = st_q.convg_cfg[6:3];
        st_d.gout.volt_bend_active       = gauge_in.averaged_cell_voltage
                                         < gauge_in.low_voltage_threshold;
        st_d.gout.cap_bend_active        = !st_d.gout.volt_bend_active
                                         && gauge_in.reported_charge_pct[15:8] < eff_thr;
        st_d.gout.volt_bend_num          = gauge_in.cell_voltage
                                         - gauge_in.empty_voltage;
        st_d.gout.volt_bend_den          = lv_off_mv;
        st_d.gout.metal_tempco           = st_q.metal_tempco;
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_int_n) begin
        if (!rst_int_n) begin
            st_q               <= '0;
            st_q.rsp.hreadyout <= 1'b1;
            st_q.temp_gain     <= gcc_pkg::RST_TEMP_GAIN;
            st_q.temp_offset   <= gcc_pkg::RST_ZERO;
            st_q.cv_state      <= gcc_pkg::GCC_CV_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    assign ahb_rsp   = st_q.rsp;
    assign gauge_out = st_q.gout;
    assign irq       = st_q.irq;

endmodule
